// file: hdl/ccp_pkg.sv
// Shared constants and types of the codec control port host
package ccp_pkg;
	// ---------------------------------------------------------------
	// Link timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 8000;
	localparam int LINK_QUARTER_NS = 625;
	localparam int LINK_QUARTER_CYC =
		(LINK_QUARTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TICK_W = 8;

	// ---------------------------------------------------------------
	// Frame contents
	// ---------------------------------------------------------------
	localparam logic [7:0] SPI_DEV_WR = 8'h10;
	localparam logic [7:0] SPI_DEV_RD = 8'h20;
	localparam logic [6:0] TW_DEV_ADDR = 7'h1A;
	localparam logic [7:0] WIDE_REG_ADDR = 8'h49;
	localparam int WIDE_BIT_POS = 8;
	localparam logic [5:0] BITS_SPI16 = 6'h10;
	localparam logic [5:0] BITS_SPI24 = 6'h18;
	localparam logic [5:0] BITS_SPI32 = 6'h20;
	localparam logic [5:0] BITS_MORE_WR = 6'h09;
	localparam logic [5:0] BITS_MORE_RD = 6'h10;
	localparam logic [5:0] BITS_BYTE = 6'h08;
	localparam logic [1:0] QTR_LAST = 2'h3;

	// 2-wire byte sequence steps
	localparam logic [2:0] STP_DEVW = 3'h0;
	localparam logic [2:0] STP_CTRL = 3'h1;
	localparam logic [2:0] STP_RSTART = 3'h2;
	localparam logic [2:0] STP_DEVR = 3'h3;
	localparam logic [2:0] STP_RDATA = 3'h4;
	localparam logic [2:0] STP_WDATA = 3'h5;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		CCP_P_TW = 2'h0,
		CCP_P_S16 = 2'h1,
		CCP_P_WIDE = 2'h2
	} ccp_proto_t;

	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_START = 7'h02,
		S_SHIFT = 7'h04,
		S_ACK = 7'h08,
		S_STOP = 7'h10,
		S_CSUP = 7'h20,
		S_WAIT = 7'h40
	} ccp_state_t;

	typedef struct packed {
		logic rd;
		logic last;
		logic [7:0] addr;
		logic [8:0] data;
	} ccp_cmd_t;

	typedef struct packed {
		logic err;
		logic [8:0] data;
	} ccp_rsp_t;
endpackage

// file: hdl/ccp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ccp_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// file: hdl/ccp_tick.sv
// Quarter-bit tick generator for the link clock divider
`timescale 1ns/1ps
module ccp_tick
	import ccp_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	output logic tick
);
	localparam logic [TICK_W-1:0] TOP = TICK_W'(LINK_QUARTER_CYC - 1);
	logic [TICK_W-1:0] cnt_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= '0;
			tick <= 1'b0;
		end else begin
			tick <= (cnt_r == TOP);
			cnt_r <= (cnt_r == TOP) ? '0 : cnt_r + 1'b1;
		end
	end
endmodule

// file: hdl/ccp_host.sv
// Host controller driving the codec control port over SPI or 2-wire
`timescale 1ns/1ps
module ccp_host
	import ccp_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire ccp_pkg::ccp_cmd_t cmd,
	output logic rsp_valid,
	output ccp_pkg::ccp_rsp_t rsp,
	input wire logic mode_pin,
	output logic wide_spi_select,
	output logic link_sclk,
	output logic chip_select_n,
	output logic sdio_o,
	output logic sdio_oe,
	input wire logic sdio_i,
	input wire logic so_i
);
	import ccp_pkg::*;

	// ---------------------------------------------------------------
	// Pin inputs and link timing
	// ---------------------------------------------------------------
	logic tick;
	logic sdio_s, so_s, mode_s;

	ccp_sync #(.W(3)) u_sync (
		.clk(core_clk),
		.arst_n(arst_n),
		.d({sdio_i, so_i, mode_pin}),
		.q({sdio_s, so_s, mode_s})
	);

	ccp_tick u_tick (
		.clk(core_clk),
		.arst_n(arst_n),
		.tick(tick)
	);

	// Drive value for a data bit: push-pull in SPI, open drain on 2-wire
	function automatic logic [1:0] drive_bit(input logic b, input logic spi);
		drive_bit = spi ? {b, 1'b1} : {1'b0, ~b};
	endfunction

	// ---------------------------------------------------------------
	// Sequencer state
	// ---------------------------------------------------------------
	ccp_state_t state_r;
	ccp_proto_t proto_r;
	logic [1:0] q_r;
	logic [5:0] nbits_r;
	logic [31:0] tx_r;
	logic [31:0] rx_r;
	logic [2:0] step_r;
	logic rd_r, last_r, rxbyte_r, nack_r, err_r;
	logic wpend_r, wval_r;
	ccp_cmd_t cur_r;

	logic accept, op_done, spi_f, idle_spi;
	ccp_proto_t proto_nxt;

	assign accept = cmd_valid && cmd_ready;
	assign op_done = tick && (q_r == QTR_LAST);
	assign spi_f = (proto_r != CCP_P_TW);

	always_comb begin
		if (wide_spi_select)
			proto_nxt = CCP_P_WIDE;
		else if (mode_s)
			proto_nxt = CCP_P_S16;
		else
			proto_nxt = CCP_P_TW;
	end

	assign idle_spi = (state_r == S_IDLE) && accept &&
		(proto_nxt != CCP_P_TW) && !(proto_nxt == CCP_P_S16 && cmd.rd);

	// Quarter phase of the current link operation
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			q_r <= 2'h0;
		else if (tick && state_r != S_IDLE && state_r != S_WAIT)
			q_r <= q_r + 2'h1;
	end

	// ---------------------------------------------------------------
	// Frame sequencing
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= S_IDLE;
			proto_r <= CCP_P_TW;
			nbits_r <= '0;
			tx_r <= '0;
			step_r <= STP_DEVW;
			rd_r <= 1'b0;
			last_r <= 1'b1;
			rxbyte_r <= 1'b0;
			err_r <= 1'b0;
			cur_r <= '0;
			cmd_ready <= 1'b1;
			rsp_valid <= 1'b0;
			rsp <= '0;
		end else begin
			rsp_valid <= 1'b0;
			case (state_r)
			S_IDLE: begin
				if (accept) begin
					cmd_ready <= 1'b0;
					cur_r <= cmd;
					rd_r <= cmd.rd;
					last_r <= cmd.last;
					proto_r <= proto_nxt;
					err_r <= 1'b0;
					rxbyte_r <= 1'b0;
					step_r <= STP_DEVW;
					case (proto_nxt)
					CCP_P_S16: begin
						if (cmd.rd) begin
							// Write-only format: refuse the read
							rsp_valid <= 1'b1;
							rsp <= '{err: 1'b1, data: 9'h000};
							cmd_ready <= 1'b1;
						end else begin
							tx_r <= {cmd.addr[6:0], cmd.data, 16'h0000};
							nbits_r <= BITS_SPI16;
							last_r <= 1'b1;
							state_r <= S_SHIFT;
						end
					end
					CCP_P_WIDE: begin
						state_r <= S_SHIFT;
						if (cmd.rd) begin
							tx_r <= {SPI_DEV_RD, cmd.addr, 16'h0000};
							nbits_r <= BITS_SPI32;
						end else begin
							tx_r <= {SPI_DEV_WR, cmd.addr[6:0], cmd.data,
								8'h00};
							nbits_r <= BITS_SPI24;
						end
					end
					default: begin
						// 2-wire writes never run past three bytes
						if (!cmd.rd)
							last_r <= 1'b1;
						state_r <= S_START;
					end
					endcase
				end
			end
			S_START: begin
				if (op_done) begin
					state_r <= S_SHIFT;
					nbits_r <= BITS_BYTE;
					if (step_r == STP_RSTART) begin
						tx_r <= {TW_DEV_ADDR, 1'b1, 24'h0};
						step_r <= STP_DEVR;
					end else
						tx_r <= {TW_DEV_ADDR, 1'b0, 24'h0};
				end
			end
			S_SHIFT: begin
				if (op_done) begin
					tx_r <= {tx_r[30:0], 1'b1};
					nbits_r <= nbits_r - 6'h01;
					if (nbits_r == 6'h01) begin
						if (!spi_f)
							state_r <= S_ACK;
						else begin
							rsp_valid <= 1'b1;
							rsp <= '{err: 1'b0, data: rx_r[8:0]};
							state_r <= last_r ? S_CSUP : S_WAIT;
							cmd_ready <= !last_r;
						end
					end
				end
			end
			S_ACK: begin
				if (op_done) begin
					if (rxbyte_r) begin
						rsp_valid <= 1'b1;
						rsp <= '{err: 1'b0, data: {1'b0, rx_r[7:0]}};
						state_r <= last_r ? S_STOP : S_WAIT;
						cmd_ready <= !last_r;
					end else if (nack_r) begin
						err_r <= 1'b1;
						state_r <= S_STOP;
					end else begin
						state_r <= S_SHIFT;
						nbits_r <= BITS_BYTE;
						case (step_r)
						STP_DEVW: begin
							step_r <= STP_CTRL;
							tx_r <= {cur_r.addr[6:0],
								rd_r ? 1'b0 : cur_r.data[8], 24'h0};
						end
						STP_CTRL: begin
							if (rd_r) begin
								step_r <= STP_RSTART;
								state_r <= S_START;
							end else begin
								step_r <= STP_WDATA;
								tx_r <= {cur_r.data[7:0], 24'h0};
							end
						end
						STP_DEVR: begin
							step_r <= STP_RDATA;
							rxbyte_r <= 1'b1;
							tx_r <= '1;
						end
						default: state_r <= S_STOP;
						endcase
					end
				end
			end
			S_STOP: begin
				if (op_done) begin
					state_r <= S_IDLE;
					cmd_ready <= 1'b1;
					if (err_r || !rd_r) begin
						rsp_valid <= 1'b1;
						rsp <= '{err: err_r, data: 9'h000};
					end
				end
			end
			S_CSUP: begin
				if (op_done) begin
					state_r <= S_IDLE;
					cmd_ready <= 1'b1;
				end
			end
			S_WAIT: begin
				// Link clock parked; the device keeps its place
				if (accept) begin
					cmd_ready <= 1'b0;
					last_r <= cmd.last;
					state_r <= S_SHIFT;
					if (!spi_f) begin
						nbits_r <= BITS_BYTE;
						tx_r <= '1;
					end else if (rd_r) begin
						nbits_r <= BITS_MORE_RD;
						tx_r <= '0;
					end else begin
						nbits_r <= BITS_MORE_WR;
						tx_r <= {cmd.data, 23'h0};
					end
				end
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Sampling of returned bits
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_r <= '0;
			nack_r <= 1'b0;
		end else if (tick && q_r == 2'h2) begin
			if (state_r == S_SHIFT)
				rx_r <= {rx_r[30:0], spi_f ? so_s : sdio_s};
			if (state_r == S_ACK)
				nack_r <= sdio_s;
		end
	end

	// Wide select tracks the last committed frame whose first command writes the select register
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wpend_r <= 1'b0;
			wval_r <= 1'b0;
			wide_spi_select <= 1'b0;
		end else begin
			if (state_r == S_IDLE && accept)
				wpend_r <= !cmd.rd && cmd.addr == WIDE_REG_ADDR;
			if (state_r == S_IDLE && accept)
				wval_r <= cmd.data[WIDE_BIT_POS];
			if (wpend_r && op_done && (state_r == S_CSUP ||
				(state_r == S_STOP && !err_r)))
				wide_spi_select <= wval_r;
		end
	end

	// ---------------------------------------------------------------
	// Link pins
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			chip_select_n <= 1'b1;
		else if (idle_spi)
			chip_select_n <= 1'b0;
		else if (tick && state_r == S_CSUP && q_r == 2'h0)
			chip_select_n <= 1'b1;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			link_sclk <= 1'b1;
			sdio_o <= 1'b0;
			sdio_oe <= 1'b0;
		end else if (tick) begin
			case (state_r)
			S_START: begin
				case (q_r)
				2'h0: {link_sclk, sdio_oe} <= 2'b00;
				2'h1: link_sclk <= 1'b1;
				2'h2: {sdio_o, sdio_oe} <= 2'b01;
				default: link_sclk <= 1'b0;
				endcase
			end
			S_SHIFT, S_ACK: begin
				if (q_r == 2'h0) begin
					link_sclk <= 1'b0;
					if (state_r == S_SHIFT)
						{sdio_o, sdio_oe} <= drive_bit(tx_r[31], spi_f);
					else if (rxbyte_r)
						{sdio_o, sdio_oe} <= {1'b0, !last_r};
					else
						sdio_oe <= 1'b0;
				end else
					link_sclk <= (q_r != QTR_LAST);
			end
			S_STOP: begin
				case (q_r)
				2'h0: {link_sclk, sdio_o, sdio_oe} <= 3'b001;
				2'h1: link_sclk <= 1'b1;
				2'h2: sdio_oe <= 1'b0;
				default: link_sclk <= 1'b1;
				endcase
			end
			S_CSUP: begin
				sdio_oe <= 1'b0;
				link_sclk <= (q_r != 2'h0);
			end
			default: begin
				link_sclk <= link_sclk;
			end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_spi_msb_out:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(tick && state_r == S_SHIFT && q_r == 2'h0 && spi_f)
		|=> sdio_oe && sdio_o == $past(tx_r[31]))
	else $error("SPI bit not taken from shift register top");

	a_cs_in_frame:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(state_r == S_SHIFT && spi_f) |-> !chip_select_n)
	else $error("Chip select high during SPI shifting");

	a_cs_rise_src:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		$rose(chip_select_n) |-> $past(state_r) == S_CSUP && !link_sclk)
	else $error("Chip select rose outside frame end");

	a_start_cond:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(tick && state_r == S_START && q_r == 2'h2)
		|=> link_sclk && sdio_oe && !sdio_o)
	else $error("START not made with clock high");

	a_stop_cond:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(tick && state_r == S_STOP && q_r == 2'h2)
		|=> link_sclk && !sdio_oe ##1 state_r == S_STOP)
	else $error("STOP not made with clock high");

	a_ack_release:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(tick && state_r == S_ACK && q_r == 2'h0 && !rxbyte_r)
		|=> !sdio_oe)
	else $error("Host kept data line in the ack slot");

	a_dev_addr_tw:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(op_done && state_r == S_START)
		|=> tx_r[31:25] == TW_DEV_ADDR && nbits_r == BITS_BYTE)
	else $error("Wrong 2-wire device address loaded");

	a_wide_dev_wr:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(state_r == S_IDLE && accept && proto_nxt == CCP_P_WIDE && !cmd.rd)
		|=> tx_r[31:24] == SPI_DEV_WR && nbits_r == BITS_SPI24)
	else $error("Wide write frame not opened with write address");

	a_s16_refuse:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(state_r == S_IDLE && accept && proto_nxt == CCP_P_S16 && cmd.rd)
		|=> rsp_valid && rsp.err && chip_select_n)
	else $error("Read not refused in 16-bit SPI format");

	a_wide_update:
	assert property (@(posedge core_clk) disable iff (!arst_n)
		(wide_spi_select != $past(wide_spi_select))
		|-> $past(wpend_r) && ($past(state_r) == S_CSUP ||
			$past(state_r) == S_STOP))
	else $error("Wide select changed without a committed write");
endmodule

// file: verif/ccp_codec_model.sv
// Behavioural codec control port: SPI and 2-wire register slave
`timescale 1ns/1ps
module ccp_codec_model (
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sda,
	input wire logic mode_pin,
	output logic pull,
	output logic so
);
	import ccp_pkg::*;
	// Arbitrary unassigned location, so the hole is exercised
	localparam logic [6:0] HOLE = 7'h7F;
	logic [8:0] regs [128];
	logic [6:0] ptr;
	logic [31:0] sh;
	logic [15:0] w;
	logic [7:0] word;
	logic wide, tw, tx, ackd, on, d8, rd, wr;
	int cnt, bc, nb;
	assign wide = regs[WIDE_REG_ADDR[6:0]][WIDE_BIT_POS];
	assign tw = !mode_pin && !wide;

	function automatic logic [8:0] rd_reg(input logic [6:0] a);
		return (a == HOLE) ? 9'h000 : regs[a];
	endfunction

	task automatic wr_reg(input logic [6:0] a, input logic [8:0] d);
		if (a != HOLE)
			regs[a] = d;
	endtask

	initial begin
		foreach (regs[i]) regs[i] = 9'h000;
		{pull, so, tx, ackd, on, d8, rd, wr} = '0;
		{ptr, sh, cnt, bc, nb} = '0;
	end

	// ------
	// SPI
	// ------
	always @(negedge cs_n) begin
		cnt = 0;
		sh = '0;
	end

	always @(posedge cs_n) begin
		if (mode_pin && !wide && cnt == 16)
			wr_reg(sh[15:9], sh[8:0]);
		so = ~so; // Deselected: never show the stale bit
	end

	always @(posedge sclk) if (!cs_n && !tw) begin
		sh = {sh[30:0], sda};
		cnt++;
		if (wide && cnt == 8) begin
			rd = (sh[7:0] == SPI_DEV_RD);
			wr = (sh[7:0] == SPI_DEV_WR);
		end
		if (wr && wide && cnt == 15) ptr = sh[6:0];
		if (wr && wide && cnt > 15 && (cnt - 15) % 9 == 0) begin
			wr_reg(ptr, sh[8:0]);
			ptr++;
		end
		if (rd && wide && cnt == 16) ptr = sh[6:0];
		if (rd && wide && cnt > 16 && cnt % 16 == 0) ptr++;
	end

	always @(negedge sclk) if (!cs_n && wide && rd && cnt >= 16) begin
		w = {7'h00, rd_reg(ptr)};
		so = w[15 - cnt % 16];
	end

	// ------
	// 2-wire
	// ------
	always @(negedge sda) if (sclk && tw) begin
		{on, bc, nb, tx, ackd} = {1'b1, 32'h0, 32'h0, 1'b0, 1'b0};
	end

	// A frame whose own write left the 2-wire format still ends here
	always @(posedge sda) if (sclk && (tw || on)) begin
		on = 1'b0;
		pull = 1'b0;
	end

	// Open frame runs to its STOP, a host no-ack or a foreign device address, so a stuck ack pull cannot linger
	always @(posedge sclk) if (on) begin
		if (bc < 8) begin
			if (!tx) sh = {sh[30:0], sda};
			bc++;
		end else begin
			bc = 0;
			ackd = 1'b1;
			if (tx && sda) on = 1'b0; // Host no-ack ends the read
		end
	end

	always @(negedge sclk) if (on) begin
		if (bc == 8 && !tx) begin
			pull = 1'b1;
			case (nb)
			0: begin
				pull = (sh[7:1] == TW_DEV_ADDR);
				on = pull;
				tx = sh[0];
			end
			1: {ptr, d8} = sh[7:0];
			2: wr_reg(ptr, {d8, sh[7:0]});
			default: pull = 1'b0;
			endcase
			nb++;
		end else if (bc == 8) begin
			pull = 1'b0;
		end else if (ackd) begin
			ackd = 1'b0;
			pull = 1'b0;
			if (tx) begin
				word = 8'(rd_reg(ptr));
				ptr++;
				pull = ~word[7];
			end
		end else if (tx) begin
			pull = ~word[7 - bc];
		end
	end
endmodule

// file: verif/test_codec_control_port.sv
// Self-checking bench of the codec control port host
`timescale 1ns/1ps
module test_codec_control_port;
	import ccp_pkg::*;
	logic core_clk, arst_n, cmd_valid, mode_pin, so_i, pull;
	logic cmd_ready, rsp_valid, wide_spi_select, link_sclk;
	logic chip_select_n, sdio_o, sdio_oe;
	ccp_cmd_t cmd;
	ccp_rsp_t rsp;
	int err_total, n_checks;
	logic [8:0] d1, d2, d3;
	logic [6:0] a3;
	wire sdio = (sdio_oe ? sdio_o : 1'b1) & ~pull; // Pulled-up data wire

	ccp_host dut (.core_clk(core_clk), .arst_n(arst_n),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
		.rsp_valid(rsp_valid), .rsp(rsp), .mode_pin(mode_pin),
		.wide_spi_select(wide_spi_select), .link_sclk(link_sclk),
		.chip_select_n(chip_select_n), .sdio_o(sdio_o),
		.sdio_oe(sdio_oe), .sdio_i(sdio), .so_i(so_i));

	ccp_codec_model codec (.sclk(link_sclk), .cs_n(chip_select_n),
		.sda(sdio), .mode_pin(mode_pin), .pull(pull), .so(so_i));

	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 40000);
		if (cmd_ready !== 1'b1) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, cmd_ready, 1'b1);
		end
	endtask

	task automatic xfer(input logic rd, input logic last,
		input logic [7:0] a, input logic [8:0] d, output ccp_rsp_t r);
		int n;
		wait_rdy();
		@(posedge core_clk);
		cmd_valid <= 1'b1;
		cmd <= '{rd, last, a, d};
		@(posedge core_clk);
		cmd_valid <= 1'b0;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 40000);
		if (rsp_valid !== 1'b1) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, rsp_valid, 1'b1);
		end
		r = rsp;
	endtask

	task automatic set_mode(input logic m);
		@(posedge core_clk);
		mode_pin <= m;
		repeat (4) @(posedge core_clk);
	endtask

	initial begin
		#800000;
		err_total++;
		$display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		conclude();
	end

	initial begin
		ccp_rsp_t r;
		void'($urandom(32'h7F97B2E5));
		{arst_n, cmd_valid, mode_pin} = 3'h0;
		cmd = '0;
		repeat (12) @(posedge core_clk);
		arst_n <= 1'b1;
		@(negedge core_clk);
		chk(cmd_ready, 1'b1);
		chk({chip_select_n, link_sclk, wide_spi_select}, 3'h6);
		$display("test reset done");
		// ------
		// 2-wire write enters the wide formats
		// ------
		set_mode(1'b0);
		xfer(1'b0, 1'b1, WIDE_REG_ADDR, 9'h100, r);
		chk(r.err, 1'b0);
		wait_rdy();
		chk(codec.regs[7'h49], 9'h100);
		chk(wide_spi_select, 1'b1);
		$display("test tw_write done");
		d1 = 9'($urandom);
		d2 = 9'($urandom);
		xfer(1'b0, 1'b0, 8'h7F, d1, r);
		xfer(1'b0, 1'b1, 8'h00, d2, r);
		wait_rdy();
		chk(codec.regs[0], d2);
		$display("test wide_write done");
		// ------
		// Wide read over the hole and the wrap
		// ------
		xfer(1'b1, 1'b0, 8'h7F, 9'h000, r);
		chk(r, 10'h000);
		xfer(1'b1, 1'b1, 8'h00, 9'h000, r);
		chk(r, {1'b0, d2});
		$display("test wide_read done");
		xfer(1'b0, 1'b1, WIDE_REG_ADDR, 9'h000, r);
		wait_rdy();
		chk(codec.regs[7'h49], 9'h000);
		chk(wide_spi_select, 1'b0);
		$display("test wide_exit done");
		// ------
		// 16-bit SPI: refused read, then a write
		// ------
		set_mode(1'b1);
		xfer(1'b1, 1'b1, 8'h10, 9'h000, r);
		chk(r.err, 1'b1);
		a3 = 7'($urandom_range(63, 1));
		d3 = 9'($urandom);
		xfer(1'b0, 1'b1, {1'b0, a3}, d3, r);
		wait_rdy();
		chk(codec.regs[a3], d3);
		$display("test spi16 done");
		set_mode(1'b0);
		xfer(1'b1, 1'b0, 8'h7F, 9'h000, r);
		chk(r, 10'h000);
		xfer(1'b1, 1'b1, 8'h00, 9'h000, r);
		chk(r, {2'h0, d2[7:0]});
		$display("test tw_read done");
		conclude();
	end
endmodule
